// File: low_voltage_reset_map.vh
// Register map, field positions, reset values and timing for the supply monitor.
// Included by the supply monitor design; defines only.
`ifndef LOW_VOLTAGE_RESET_MAP_VH
`define LOW_VOLTAGE_RESET_MAP_VH

// ----------------------------------------------------------------
// Byte offsets on APB
// ----------------------------------------------------------------
`define OFS_SUPPLY_MONITOR_CONTROL 12'h000
`define OFS_SUPPLY_LEVEL_STATUS    12'h004
`define OFS_RESET_CAUSE            12'h008
`define OFS_SEQUENCER_STATE        12'h00c

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BIT_COMPARE_SOURCE_SELECT  5
`define BIT_RESET_THRESHOLD_SELECT 3
`define BIT_FALL_INTERRUPT_ENABLE  1
`define BIT_RISE_INTERRUPT_ENABLE  0
`define BIT_SUPPLY_FALL_FLAG       1
`define BIT_SUPPLY_RISE_FLAG       0
`define BIT_POWERON_OR_LOWVOLT     1
`define BIT_WATCHDOG_CAUSE         0

// ----------------------------------------------------------------
// Reset and fixed read values
// ----------------------------------------------------------------
`define CONTROL_RESET      8'hfc
`define CONTROL_FIXED_ONES 8'hd4
`define STATUS_FIXED_ONES  8'hfc
`define CAUSE_RESET        2'h2

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define MCLK_PERIOD_PS     5000
`define PIN_FILTER_NS      400
`define PRESCALE_CYCLES    131072

`endif

// File: low_voltage_reset_status.v
// Supply monitor digital side: supply flags, reset cause, reset release sequence.
// Assumes comparator outputs and reset pin are asynchronous levels; APB master
// and watchdog reset pulse run on mclk.
//
// How it works
// - Supply fall sets supply fall flag
// - Rise flag: armed fall, recover, no lower dip
// - Clear flag by 0 only after read 1
// - Low-voltage reset clears both supply flags
// - Status bits 7..2 read one, ignore writes
// - Power-on/low-volt reset sets cause bit; write 0 clears
// - Watchdog reset sets watchdog cause bit
// - Watchdog cause cleared by resets or write 0
// - Cause bits 7..2 undefined, writes ignored
// - Low reset pin holds prescaler and chip
// - Pin released: count 131072 cycles, then release
// - Filter reset pin glitches under 400 ns
// - Low-voltage detector always on, no disable
// - Below threshold: drive reset low, clear prescaler
// - Low-voltage reset holds until supply rises above upper threshold or power-on reset
// - Above upper threshold: release, count, then run
// - Low-voltage reset restores high threshold select and clears both interrupt enables
// - Supply below power-on level forces power-on reset
// - Fall flag with enable raises interrupt zero
// - Threshold select 0 lower, 1 higher
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "low_voltage_reset_map.vh"

module low_voltage_reset_status
#(
   parameter PRESCALE_CYCLES = `PRESCALE_CYCLES,
   parameter PRESCALE_WIDTH  = 18
)
(
   // Clock and reset
   input  wire        mclk,
   input  wire        sys_rst,
   // APB slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output wire        pready,
   output reg  [31:0] prdata,
   output wire        pslverr,
   // Asynchronous comparator levels and reset pin; below_* high when supply is below the level, above_rise_level high when above
   input  wire        below_fall_level,
   input  wire        above_rise_level,
   input  wire        below_lower_threshold,
   input  wire        below_upper_threshold,
   input  wire        below_poweron_level,
   input  wire        reset_pin_n,
   // Watchdog reset event from same clock domain
   input  wire        watchdog_reset,
   // Reset and interrupt outputs
   output reg         low_voltage_reset_n,
   output reg         chip_reset,
   output reg         prescaler_overflow,
   output reg         external_interrupt_zero,
   output wire        reset_threshold_select,
   output wire        compare_source_select
);

   // ----------------------------------------------------------------
   // Derived timing
   // ----------------------------------------------------------------
   localparam integer FILTER_CYCLES =
      (`PIN_FILTER_NS * 1000 + `MCLK_PERIOD_PS - 1) / `MCLK_PERIOD_PS;
   localparam integer FILTER_LAST_INT   = FILTER_CYCLES - 1;
   localparam integer PRESCALE_LAST_INT = PRESCALE_CYCLES - 1;
   localparam [7:0] FILTER_LAST = FILTER_LAST_INT[7:0];
   localparam [PRESCALE_WIDTH-1:0] PRESCALE_LAST = PRESCALE_LAST_INT[PRESCALE_WIDTH-1:0];
   localparam [1:0] CAUSE_INIT = `CAUSE_RESET;

   // Sequencer states
   localparam [1:0] ST_HOLD  = 2'h0;
   localparam [1:0] ST_COUNT = 2'h1;
   localparam [1:0] ST_RUN   = 2'h2;

   function is_access;
      input [11:0] addr;
      input [11:0] ofs;
      begin
         is_access = psel && penable && (addr == ofs);
      end
   endfunction

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   reg  [5:0] sync1_reg;
   reg  [5:0] sync2_reg;
   reg  [5:0] sync_prev_reg;
   wire [5:0] async_in = {reset_pin_n, below_poweron_level, below_upper_threshold,
                          below_lower_threshold, above_rise_level, below_fall_level};

   always @(posedge mclk)
   begin
      if (sys_rst)
      begin
         sync1_reg     <= 6'h20;
         sync2_reg     <= 6'h20;
         sync_prev_reg <= 6'h20;
      end
      else
      begin
         sync1_reg     <= async_in;
         sync2_reg     <= sync1_reg;
         sync_prev_reg <= sync2_reg;
      end
   end

   wire fall_s   = sync2_reg[0];
   wire rise_s   = sync2_reg[1];
   wire lower_s  = sync2_reg[2];
   wire upper_s  = sync2_reg[3];
   wire por_s    = sync2_reg[4];
   wire pin_s    = sync2_reg[5];
   wire fall_evt = fall_s && !sync_prev_reg[0];
   wire rise_evt = rise_s && !sync_prev_reg[1];

   // ----------------------------------------------------------------
   // Reset pin filter
   // ----------------------------------------------------------------
   reg       pin_filt_reg;
   reg [7:0] filt_cnt_reg;

   always @(posedge mclk)
   begin
      if (sys_rst)
      begin
         pin_filt_reg <= 1'b1;
         filt_cnt_reg <= 8'h00;
      end
      else if (pin_s == pin_filt_reg)
         filt_cnt_reg <= 8'h00;
      else if (filt_cnt_reg == FILTER_LAST)
      begin
         pin_filt_reg <= pin_s;
         filt_cnt_reg <= 8'h00;
      end
      else
         filt_cnt_reg <= filt_cnt_reg + 8'h01;
   end

   // Pin assertion event for the watchdog cause clear
   reg  pin_filt_prev_reg;
   wire pin_assert_evt = pin_filt_prev_reg && !pin_filt_reg;

   always @(posedge mclk)
   begin
      if (sys_rst)
         pin_filt_prev_reg <= 1'b1;
      else
         pin_filt_prev_reg <= pin_filt_reg;
   end

   // ----------------------------------------------------------------
   // Control register
   // ----------------------------------------------------------------
   // Detector has no enable bit at all, so software cannot switch it off
   reg  fall_ie_reg;
   reg  rise_ie_reg;
   reg  thresh_sel_reg;
   reg  src_sel_reg;
   reg  lvr_active_reg;
   wire wr_ctrl = is_access(paddr, `OFS_SUPPLY_MONITOR_CONTROL) && pwrite;
   wire lvr_enter;

   assign reset_threshold_select = thresh_sel_reg;
   assign compare_source_select  = src_sel_reg;

   always @(posedge mclk)
   begin
      if (sys_rst || por_s || watchdog_reset)
      begin
         fall_ie_reg    <= 1'b0;
         rise_ie_reg    <= 1'b0;
         thresh_sel_reg <= 1'b1;
         src_sel_reg    <= 1'b1;
      end
      else if (lvr_enter || lvr_active_reg)
      begin
         fall_ie_reg    <= 1'b0;
         rise_ie_reg    <= 1'b0;
         thresh_sel_reg <= 1'b1;
      end
      else if (wr_ctrl)
      begin
         fall_ie_reg    <= pwdata[`BIT_FALL_INTERRUPT_ENABLE];
         rise_ie_reg    <= pwdata[`BIT_RISE_INTERRUPT_ENABLE];
         thresh_sel_reg <= pwdata[`BIT_RESET_THRESHOLD_SELECT];
         src_sel_reg    <= pwdata[`BIT_COMPARE_SOURCE_SELECT];
      end
   end

   // ----------------------------------------------------------------
   // Low-voltage reset detector
   // ----------------------------------------------------------------
   wire below_sel = thresh_sel_reg ? upper_s : lower_s;
   assign lvr_enter = below_sel && !lvr_active_reg;

   always @(posedge mclk)
   begin
      if (sys_rst || por_s)
         lvr_active_reg <= 1'b0;
      else if (lvr_enter)
         lvr_active_reg <= 1'b1;
      else if (lvr_active_reg && !upper_s)
         lvr_active_reg <= 1'b0;
   end

   // ----------------------------------------------------------------
   // Supply flags
   // ----------------------------------------------------------------
   reg  fall_flag_reg;
   reg  rise_flag_reg;
   reg  fall_seen_reg;
   reg  rise_seen_reg;
   reg  rise_armed_reg;
   wire rd_stat = is_access(paddr, `OFS_SUPPLY_LEVEL_STATUS) && !pwrite;
   wire wr_stat = is_access(paddr, `OFS_SUPPLY_LEVEL_STATUS) && pwrite;
   wire fall_clr = wr_stat && fall_seen_reg && !pwdata[`BIT_SUPPLY_FALL_FLAG];
   wire rise_clr = wr_stat && rise_seen_reg && !pwdata[`BIT_SUPPLY_RISE_FLAG];
   wire rise_set = rise_armed_reg && rise_evt && !lower_s;

   always @(posedge mclk)
   begin
      if (sys_rst || por_s || lvr_enter || lvr_active_reg)
      begin
         fall_flag_reg  <= 1'b0;
         rise_flag_reg  <= 1'b0;
         fall_seen_reg  <= 1'b0;
         rise_seen_reg  <= 1'b0;
         rise_armed_reg <= 1'b0;
      end
      else
      begin
         if (fall_evt)
            fall_flag_reg <= 1'b1;
         else if (fall_clr)
            fall_flag_reg <= 1'b0;

         if (rise_set)
            rise_flag_reg <= 1'b1;
         else if (rise_clr)
            rise_flag_reg <= 1'b0;

         // A write consumes the read; a 0 with no prior read of 1 is ignored
         if (rd_stat)
            fall_seen_reg <= prdata[`BIT_SUPPLY_FALL_FLAG];
         else if (wr_stat)
            fall_seen_reg <= 1'b0;
         if (rd_stat)
            rise_seen_reg <= prdata[`BIT_SUPPLY_RISE_FLAG];
         else if (wr_stat)
            rise_seen_reg <= 1'b0;

         if (lower_s)
            rise_armed_reg <= 1'b0;
         else if (fall_evt && rise_ie_reg)
            rise_armed_reg <= 1'b1;
         else if (rise_set)
            rise_armed_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Reset cause
   // ----------------------------------------------------------------
   reg  poweron_or_lowvolt_cause_reg;
   reg  watchdog_cause_reg;
   wire wr_cause = is_access(paddr, `OFS_RESET_CAUSE) && pwrite;

   always @(posedge mclk)
   begin
      if (sys_rst)
      begin
         poweron_or_lowvolt_cause_reg <= CAUSE_INIT[`BIT_POWERON_OR_LOWVOLT];
         watchdog_cause_reg           <= 1'b0;
      end
      else
      begin
         if (por_s || lvr_enter)
            poweron_or_lowvolt_cause_reg <= 1'b1;
         else if (wr_cause && !pwdata[`BIT_POWERON_OR_LOWVOLT])
            poweron_or_lowvolt_cause_reg <= 1'b0;

         if (watchdog_reset)
            watchdog_cause_reg <= 1'b1;
         else if (por_s || lvr_enter || pin_assert_evt)
            watchdog_cause_reg <= 1'b0;
         else if (wr_cause && !pwdata[`BIT_WATCHDOG_CAUSE])
            watchdog_cause_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Release sequencer
   // ----------------------------------------------------------------
   reg [1:0]                state_reg;
   reg [1:0]                state_next;
   reg [PRESCALE_WIDTH-1:0] presc_reg;
   wire hold = por_s || lvr_active_reg || lvr_enter || !pin_filt_reg;

   always @*
   begin
      state_next = state_reg;
      case (state_reg)
         ST_HOLD:
            if (!hold)
               state_next = ST_COUNT;
         ST_COUNT:
            if (hold)
               state_next = ST_HOLD;
            else if (presc_reg == PRESCALE_LAST)
               state_next = ST_RUN;
         ST_RUN:
            if (hold)
               state_next = ST_HOLD;
         default:
            state_next = ST_HOLD;
      endcase
   end

   always @(posedge mclk)
   begin
      if (sys_rst)
      begin
         state_reg               <= ST_HOLD;
         presc_reg               <= {PRESCALE_WIDTH{1'b0}};
         chip_reset              <= 1'b1;
         prescaler_overflow      <= 1'b0;
         low_voltage_reset_n     <= 1'b1;
         external_interrupt_zero <= 1'b0;
      end
      else
      begin
         state_reg          <= state_next;
         prescaler_overflow <= (state_reg == ST_COUNT) && (state_next == ST_RUN);
         chip_reset         <= (state_next != ST_RUN);
         if (state_reg == ST_COUNT && !hold)
            presc_reg <= presc_reg + {{(PRESCALE_WIDTH-1){1'b0}}, 1'b1};
         else
            presc_reg <= {PRESCALE_WIDTH{1'b0}};
         low_voltage_reset_n     <= !(lvr_active_reg || lvr_enter);
         external_interrupt_zero <= (fall_flag_reg && fall_ie_reg) ||
                                    (rise_flag_reg && rise_ie_reg);
      end
   end

   // ----------------------------------------------------------------
   // APB read path
   // ----------------------------------------------------------------
   // Zero wait states; unmapped addresses answer with an error
   wire mapped = (paddr == `OFS_SUPPLY_MONITOR_CONTROL) ||
                 (paddr == `OFS_SUPPLY_LEVEL_STATUS) ||
                 (paddr == `OFS_RESET_CAUSE) ||
                 (paddr == `OFS_SEQUENCER_STATE);

   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped;

   reg [31:0] rd_word;

   always @*
   begin
      case (paddr)
         `OFS_SUPPLY_MONITOR_CONTROL:
            rd_word = {24'h000000, `CONTROL_FIXED_ONES | {2'h0, src_sel_reg, 1'b0,
                      thresh_sel_reg, 1'b0, fall_ie_reg, rise_ie_reg}};
         `OFS_SUPPLY_LEVEL_STATUS:
            rd_word = {24'h000000, `STATUS_FIXED_ONES | {6'h00, fall_flag_reg,
                      rise_flag_reg}};
         `OFS_RESET_CAUSE:
            rd_word = {30'h00000000, poweron_or_lowvolt_cause_reg,
                       watchdog_cause_reg};
         `OFS_SEQUENCER_STATE:
            rd_word = {28'h0000000, lvr_active_reg, !pin_filt_reg, state_reg};
         default:
            rd_word = 32'h00000000;
      endcase
   end

   // Captured in setup: access phase sees a flop, flag clears see what was read
   always @(posedge mclk)
   begin
      if (sys_rst)
         prdata <= 32'h00000000;
      else if (psel && !penable)
         prdata <= rd_word;
   end

endmodule

// File: low_voltage_reset_assertions.sv
// Port-level checks on the supply monitor: register reads, reset release.
// Assumes one mclk domain with synchronous active-high sys_rst.
`timescale 1ns/10ps
module low_voltage_reset_checks
#(
   parameter PRESCALE_CYCLES = 131072
)
(
   // Clock and reset
   input wire        mclk,
   input wire        sys_rst,
   // APB
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] prdata,
   // Raw hold causes
   input wire        below_poweron_level,
   input wire        reset_pin_n,
   // Reset and interrupt outputs
   input wire        low_voltage_reset_n,
   input wire        chip_reset,
   input wire        prescaler_overflow,
   input wire        external_interrupt_zero,
   input wire        reset_threshold_select,
   input wire        compare_source_select
);
   // -----------------------------------------
   // Quiet time since the last raw hold cause
   // -----------------------------------------
   // Counts from the raw inputs, so sync and filter delays need slack
   reg [31:0] quiet_reg;
   always @(posedge mclk)
      if (sys_rst || !low_voltage_reset_n || !reset_pin_n || below_poweron_level)
         quiet_reg <= 32'h0;
      else
         quiet_reg <= quiet_reg + 32'h1;

   // -----------------------------------------
   // Assertions
   // -----------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   a_status_ones:
      assert property (psel && penable && !pwrite && paddr == 12'h004 |-> prdata[31:2] == 30'h3f)
      else $error("status upper bits not ones");
   a_cause_upper:
      assert property (psel && penable && !pwrite && paddr == 12'h008 |-> prdata[31:2] == 30'h0)
      else $error("cause upper bits changed");
   a_select_mirror:
      assert property (psel && penable && !pwrite && paddr == 12'h000
         |-> prdata[3] == $past(reset_threshold_select)
             && prdata[5] == $past(compare_source_select))
      else $error("control read differs from select outputs");
   a_lvr_holds_chip:
      assert property (!low_voltage_reset_n |-> chip_reset && !prescaler_overflow)
      else $error("chip released during low-voltage reset");
   a_lvr_high_select:
      assert property ($fell(low_voltage_reset_n) |-> ##[0:2] reset_threshold_select)
      else $error("threshold select not restored");
   a_lvr_clears_irq:
      assert property ($fell(low_voltage_reset_n) |-> ##[0:2] !external_interrupt_zero)
      else $error("interrupt survives low-voltage reset");
   a_overflow_pulse:
      assert property (prescaler_overflow |=> !prescaler_overflow)
      else $error("overflow longer than one cycle");
   a_overflow_release:
      assert property (prescaler_overflow |-> ##[0:1] !chip_reset)
      else $error("overflow without release");
   a_release_count:
      assert property ($fell(chip_reset)
         |-> quiet_reg >= PRESCALE_CYCLES && quiet_reg <= PRESCALE_CYCLES + 100)
      else $error("release count out of range");
endmodule

bind low_voltage_reset_status low_voltage_reset_checks #(.PRESCALE_CYCLES(PRESCALE_CYCLES)) i_chk (
   .mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .prdata(prdata), .below_poweron_level(below_poweron_level),
   .reset_pin_n(reset_pin_n), .low_voltage_reset_n(low_voltage_reset_n),
   .chip_reset(chip_reset), .prescaler_overflow(prescaler_overflow),
   .external_interrupt_zero(external_interrupt_zero),
   .reset_threshold_select(reset_threshold_select),
   .compare_source_select(compare_source_select));

// File: tb_top.sv
// Self-checking bench for the supply monitor; APB reads queued, compared on completion.
// Assumes the slave answers by pready alone and a shortened release prescaler.
`timescale 1ns/10ps
module tb_top;
   localparam int PRE = 16;
   logic        mclk;
   logic        sys_rst;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        below_fall_level;
   logic        above_rise_level;
   logic        below_lower_threshold;
   logic        below_upper_threshold;
   logic        below_poweron_level;
   logic        reset_pin_n;
   logic        watchdog_reset;
   logic        low_voltage_reset_n;
   logic        chip_reset;
   logic        prescaler_overflow;
   logic        external_interrupt_zero;
   logic        reset_threshold_select;
   logic        compare_source_select;
   logic [32:0] exp_q[$];
   int          errors;
   int          comparisons;
   int          seed;

   low_voltage_reset_status #(.PRESCALE_CYCLES(PRE)) i_dut (
      .mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .below_fall_level(below_fall_level), .above_rise_level(above_rise_level),
      .below_lower_threshold(below_lower_threshold),
      .below_upper_threshold(below_upper_threshold),
      .below_poweron_level(below_poweron_level), .reset_pin_n(reset_pin_n),
      .watchdog_reset(watchdog_reset), .low_voltage_reset_n(low_voltage_reset_n),
      .chip_reset(chip_reset), .prescaler_overflow(prescaler_overflow),
      .external_interrupt_zero(external_interrupt_zero),
      .reset_threshold_select(reset_threshold_select),
      .compare_source_select(compare_source_select));

   // -----------------------------------------
   // Clock, watchdog, verdict
   // -----------------------------------------
   initial
   begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   initial
   begin
      #50000;
      errors++;
      end_sim;
   end

   task automatic end_sim;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // -----------------------------------------
   // Drivers and compares
   // -----------------------------------------
   task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d);
      @(posedge mclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= ($urandom << 8) | {24'h0, d};
      @(posedge mclk);
      penable <= 1'b1;
      // Only the watchdog ends a wait that never sees pready
      do
         @(posedge mclk);
      while (pready !== 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic err = 1'b0);
      exp_q.push_back({err, e});
      apb(a, 1'b0, 8'h00);
   endtask

   task automatic cmp_read(input logic [32:0] e, input logic [32:0] s);
      comparisons++;
      if (s !== e)
      begin
         errors++;
         $display("[FAIL] apb_read expected %h seen %h", e, s);
      end
   endtask

   // Value is taken at the call, before that edge's updates; the wait spaces checks
   task automatic chk(input string nm, input logic s, input logic e);
      @(negedge mclk);
      comparisons++;
      if (s !== e)
      begin
         errors++;
         $display("[FAIL] %s expected %b seen %b", nm, e, s);
      end
   endtask

   task automatic run_in(input int lo, input int hi);
      int c;
      for (c = 0; c < 1000 && chip_reset !== 1'b0; c++)
         @(negedge mclk);
      chk("overflow_pulse", prescaler_overflow, 1'b1);
      chk("release_cycles", c >= lo && c <= hi, 1'b1);
   endtask

   task automatic done(input string nm);
      $display("test %s finished", nm);
   endtask

   always @(posedge mclk)
      if (psel && penable && pready && !pwrite)
         cmp_read(exp_q.pop_front(), {pslverr, prdata});

   // -----------------------------------------
   // Tests
   // -----------------------------------------
   initial
   begin
      {psel, penable, pwrite, watchdog_reset, below_fall_level, below_lower_threshold} = '0;
      {below_upper_threshold, below_poweron_level, paddr, pwdata} = '0;
      {above_rise_level, reset_pin_n, sys_rst} = 3'h7;
      seed = $urandom(32'h76ad);
      repeat (2) @(posedge mclk);
      sys_rst <= 1'b0;
      run_in(PRE, PRE + 8);
      rd(12'h000, 32'hfc);
      rd(12'h004, 32'hfc);
      rd(12'h008, 32'h02);
      rd(12'h010, 32'h0, 1'b1);
      apb(12'h008, 1'b1, 8'h00);
      rd(12'h008, 32'h00);
      done("register reset values");

      apb(12'h000, 1'b1, 8'h03);
      rd(12'h000, 32'hd7);
      apb(12'h004, 1'b1, 8'($urandom) & 8'hfc);
      below_fall_level <= 1'b1;
      above_rise_level <= 1'b0;
      repeat (6) @(posedge mclk);
      chk("irq_fall", external_interrupt_zero, 1'b1);
      apb(12'h004, 1'b1, 8'h00);
      rd(12'h004, 32'hfe);
      below_fall_level <= 1'b0;
      above_rise_level <= 1'b1;
      repeat (6) @(posedge mclk);
      apb(12'h004, 1'b1, 8'h00);
      rd(12'h004, 32'hfd);
      apb(12'h004, 1'b1, 8'h00);
      rd(12'h004, 32'hfc);
      chk("irq_idle", external_interrupt_zero, 1'b0);
      done("supply flags");

      @(posedge mclk);
      below_upper_threshold <= 1'b1;
      below_fall_level <= 1'b1;
      above_rise_level <= 1'b0;
      repeat (6) @(posedge mclk);
      chk("lvr_upper_only", low_voltage_reset_n, 1'b1);
      @(posedge mclk);
      below_lower_threshold <= 1'b1;
      repeat (6) @(posedge mclk);
      chk("lvr_active", low_voltage_reset_n, 1'b0);
      chk("lvr_chip", chip_reset, 1'b1);
      chk("lvr_select", reset_threshold_select, 1'b1);
      chk("lvr_source", compare_source_select, 1'b0);
      rd(12'h000, 32'hdc);
      rd(12'h004, 32'hfc);
      below_lower_threshold <= 1'b0;
      repeat (6) @(posedge mclk);
      chk("lvr_stays", low_voltage_reset_n, 1'b0);
      @(posedge mclk);
      below_upper_threshold <= 1'b0;
      below_fall_level <= 1'b0;
      above_rise_level <= 1'b1;
      run_in(PRE, PRE + 8);
      rd(12'h008, 32'h02);
      done("low-voltage reset");

      watchdog_reset <= 1'b1;
      @(posedge mclk);
      watchdog_reset <= 1'b0;
      repeat (2) @(posedge mclk);
      rd(12'h008, 32'h03);
      apb(12'h008, 1'b1, 8'h01);
      rd(12'h008, 32'h01);
      reset_pin_n <= 1'b0;
      repeat (20) @(posedge mclk);
      reset_pin_n <= 1'b1;
      repeat (4) @(posedge mclk);
      chk("pin_glitch", chip_reset, 1'b0);
      @(posedge mclk);
      reset_pin_n <= 1'b0;
      repeat (100) @(posedge mclk);
      chk("pin_hold", chip_reset, 1'b1);
      @(posedge mclk);
      reset_pin_n <= 1'b1;
      run_in(PRE + 80, PRE + 92);
      rd(12'h008, 32'h00);
      done("watchdog and reset pin");

      watchdog_reset <= 1'b1;
      @(posedge mclk);
      watchdog_reset <= 1'b0;
      below_poweron_level <= 1'b1;
      repeat (6) @(posedge mclk);
      chk("poweron_hold", chip_reset, 1'b1);
      @(posedge mclk);
      below_poweron_level <= 1'b0;
      run_in(PRE, PRE + 8);
      rd(12'h008, 32'h02);
      done("power-on reset");
      end_sim;
   end
endmodule
